// [aro_host_model.sv]
/*
 * host model reading results from the serial result port
 * assumes the bench resolves clock and data pin levels
 */
`timescale 1ns/1ns
module aro_host_model (
    input  wire logic        sclkLine,
    input  wire logic        dataLine,
    output      logic        sclkDrv,
    output      logic        sclkDrvOe,
    output      logic [23:0] word,
    output      int          bitCount
);
    // ****************************************************
    // host receiver
    // ****************************************************
    initial begin
        sclkDrv   = 1'b1;
        sclkDrvOe = 1'b0;
        word      = 24'h000000;
        bitCount  = 0;
    end
    always @(posedge sclkLine) begin
        word     = {word[22:0], dataLine};
        bitCount = bitCount + 1;
    end
    task automatic clear_word();
        word     = 24'h000000;
        bitCount = 0;
    endtask
    task automatic read_word(input bit batched);
        sclkDrvOe = 1'b1;
        #2;
        for (int i = 0; i < 24; i++) begin
            sclkDrv = 1'b0;
            #62;
            sclkDrv = 1'b1;
            #63;
            if (batched && i % 8 == 7) #400;
        end
        sclkDrvOe = 1'b0;
    endtask
endmodule

// [aro_pkg.sv]
/*
 * shared constants of the read-only serial result port
 * assumes one 100 MHz system clock and a crystal clock sampled as a pin
 */
package aro_pkg;

    // ****************************************************
    // result word
    // ****************************************************
    localparam int         WORD_BITS  = 24;
    localparam int         INDEX_W    = 5;
    localparam logic [4:0] INDEX_LAST = 5'h17;
    localparam logic [4:0] INDEX_DONE = 5'h18;

    // ****************************************************
    // conversion timing in crystal periods
    // ****************************************************
    localparam int          DIV_FILTER  = 69;
    localparam int          DIV_DECIM   = 8;
    localparam int          DIV_STAGE   = 3;
    localparam int          TICK_W      = 11;
    localparam int          CONV_TICKS  = DIV_FILTER * DIV_DECIM * DIV_STAGE;
    localparam logic [10:0] TICK_LAST   = 11'(CONV_TICKS - 1);
    localparam logic [10:0] TICK_PRE    = 11'(CONV_TICKS - 2);
    localparam logic [1:0]  SETTLE_LAST = 2'h1;

    // ****************************************************
    // pin levels and read states
    // ****************************************************
    localparam logic MODE_MASTER = 1'b0;

    typedef enum logic [1:0] {
        RD_STANDBY,
        RD_BUSY,
        RD_READY,
        RD_SHIFT
    } aro_read_type;

endpackage

// [aro_port.sv]
/*
 * read-only serial result port of a converter, master or slave clocking
 * assumes pins csN, modeSel, crystalClock and sclkIn are asynchronous,
 * resultData comes from the filter on clk
 */
`timescale 1ns/1ns
module aro_port
    import aro_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 csN,
    input  wire logic                 modeSel,
    input  wire logic                 crystalClock,
    input  wire logic                 sclkIn,
    input  wire logic [WORD_BITS-1:0] resultData,
    output      logic                 sclkOut,
    output      logic                 sclkOe,
    output      logic                 doutRdy,
    output      logic                 doutOe,
    output      logic                 standby
);

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic [3:0]         syncA;
    logic [3:0]         syncB;
    logic               xtalLast;
    logic               sclkLast;
    logic               sel;
    logic               master;
    logic               xtalRise;
    logic               xtalFall;
    logic               sclkRise;
    logic               sclkFall;
    logic               riseEdge;
    logic               fallEdge;
    logic [TICK_W-1:0]  tickCnt;
    logic [1:0]         settleCnt;
    logic               convDone;
    logic               preUpdate;
    aro_read_type       rdState;
    aro_read_type       next_rdState;
    logic               serialBit;
    logic [INDEX_W-1:0] bitIndex;
    logic               advance;
    logic               count;

    always_ff @(posedge clk) begin
        if (rst) begin
            syncA    <= 4'hF;
            syncB    <= 4'hF;
            xtalLast <= 1'b1;
            sclkLast <= 1'b1;
        end else begin
            syncA    <= {csN, modeSel, crystalClock, sclkIn};
            syncB    <= syncA;
            xtalLast <= syncB[1];
            sclkLast <= syncB[0];
        end
    end

    assign sel      = ~syncB[3];
    assign master   = (syncB[2] == MODE_MASTER);
    assign xtalRise = syncB[1] & ~xtalLast;
    assign xtalFall = ~syncB[1] & xtalLast;
    assign sclkRise = syncB[0] & ~sclkLast;
    assign sclkFall = ~syncB[0] & sclkLast;
    assign riseEdge = master ? xtalRise : sclkRise;
    assign fallEdge = master ? xtalFall : sclkFall;

    // ****************************************************
    // conversion timing
    // ****************************************************
    // one result per 1656 crystal periods
    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            tickCnt <= '0;
        end else if (xtalRise) begin
            tickCnt <= (tickCnt == TICK_LAST) ? '0 : tickCnt + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            settleCnt <= '0;
        end else if (xtalRise && tickCnt == TICK_LAST
                     && settleCnt != SETTLE_LAST) begin
            settleCnt <= settleCnt + 2'h1;
        end
    end

    assign convDone  = sel && xtalRise && tickCnt == TICK_LAST
                       && settleCnt == SETTLE_LAST;
    assign preUpdate = sel && xtalRise && tickCnt == TICK_PRE
                       && settleCnt == SETTLE_LAST;

    // ****************************************************
    // read sequencer
    // ****************************************************
    always_comb begin
        next_rdState = rdState;
        unique case (rdState)
            RD_STANDBY: begin
                if (sel) begin
                    next_rdState = RD_BUSY;
                end
            end
            RD_BUSY: begin
                if (convDone) begin
                    next_rdState = RD_READY;
                end
            end
            RD_READY: begin
                // in master mode, first clock after a crystal high half
                if (preUpdate) begin
                    next_rdState = RD_BUSY;
                end else if (fallEdge) begin
                    next_rdState = RD_SHIFT;
                end
            end
            RD_SHIFT: begin
                if (preUpdate) begin
                    next_rdState = RD_BUSY;
                // leave one cycle after the 24th rise
                end else if (bitIndex == INDEX_DONE) begin
                    next_rdState = RD_BUSY;
                end
            end
        endcase
        if (!sel) begin
            next_rdState = RD_STANDBY;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdState <= RD_STANDBY;
        end else begin
            rdState <= next_rdState;
        end
    end

    // present on fall, count on rise
    assign advance = (rdState == RD_READY || rdState == RD_SHIFT)
                     && fallEdge && !preUpdate;
    assign count   = (rdState == RD_SHIFT) && riseEdge;

    aro_shifter u_shifter (
        .clk      (clk),
        .rst      (rst),
        .clear    (!sel),
        .load     (convDone),
        .loadData (resultData),
        .advance  (advance),
        .count    (count),
        .serialBit(serialBit),
        .bitIndex (bitIndex)
    );

    // ****************************************************
    // pin drivers
    // ****************************************************
    // high unless ready or shifting
    // leaving to busy raises the line
    assign doutRdy = (rdState == RD_READY) ? 1'b0
                   : (rdState == RD_SHIFT) ? serialBit : 1'b1;

    // master drives clock, slave floats it
    always_ff @(posedge clk) begin
        if (rst) begin
            sclkOe  <= 1'b0;
            doutOe  <= 1'b0;
            standby <= 1'b1;
        end else begin
            sclkOe  <= sel && master;
            doutOe  <= sel;
            standby <= !sel;
        end
    end

    // idle high, low half in each bit
    always_ff @(posedge clk) begin
        if (rst) begin
            sclkOut <= 1'b1;
        end else if (next_rdState == RD_SHIFT && master && xtalFall) begin
            sclkOut <= 1'b0;
        end else if (xtalRise || next_rdState != RD_SHIFT) begin
            sclkOut <= 1'b1;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    localparam logic [TICK_W+1:0] SETTLE_MIN = 13'(2 * CONV_TICKS - 1);

    logic              shifting;
    logic [TICK_W+1:0] selRises;

    assign shifting = (rdState == RD_SHIFT);

    always_ff @(posedge clk) begin
        if (rst || !sel) begin
            selRises <= '0;
        end else if (xtalRise && selRises != '1) begin
            selRises <= selRises + 13'h0001;
        end
    end

    deselect_float_a: assert property (!sel |=> !doutOe && !sclkOe
        && standby && rdState == RD_STANDBY) else $error("pins not floated");
    busy_high_a: assert property ((rdState == RD_BUSY
        || selRises < SETTLE_MIN) |-> doutRdy)
        else $error("line low while converting");
    done_low_a: assert property (convDone |=> !doutRdy [*1])
        else $error("line not low at completion");
    pre_update_a: assert property (preUpdate && sel |=> doutRdy)
        else $error("line low before update");
    read_end_a: assert property (shifting && bitIndex == INDEX_DONE
        && sel |=> doutRdy && rdState == RD_BUSY)
        else $error("line low after read");
    master_wait_a: assert property ($rose(shifting) && master
        |-> $past(xtalFall) && $past(rdState) == RD_READY)
        else $error("clock too soon after ready");
    change_fall_a: assert property (shifting && $past(shifting) &&
        $changed(doutRdy) |-> $past(fallEdge))
        else $error("bit changed off a falling edge");
    master_clock_a: assert property (sel && master |=> sclkOe)
        else $error("master clock not driven");
    settle_gap_a: assert property (convDone |->
        selRises >= SETTLE_MIN) else $error("result before settling");
    idle_high_a: assert property (!shifting |-> sclkOut)
        else $error("clock not idle high");

    master_read_c: cover property (master && shifting ##1 !shifting);
    slave_read_c: cover property (!master && shifting ##1 !shifting);
    unread_drop_c: cover property (rdState == RD_READY && preUpdate);
    slave_pause_c: cover property (!master && shifting && bitIndex == 5'h08);

endmodule

// [aro_shifter.sv]
/*
 * output word holder and bit position counter
 * assumes load, advance and count are one-cycle pulses on clk
 */
`timescale 1ns/1ns
module aro_shifter
    import aro_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clear,
    input  wire logic                 load,
    input  wire logic [WORD_BITS-1:0] loadData,
    input  wire logic                 advance,
    input  wire logic                 count,
    output      logic                 serialBit,
    output      logic [INDEX_W-1:0]   bitIndex
);

    logic [WORD_BITS-1:0] word;

    // ****************************************************
    // word storage
    // ****************************************************
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            word <= '0;
        end else if (load) begin
            word <= loadData;
        end
    end

    // ****************************************************
    // bit position, kept across pauses
    // ****************************************************
    // position survives gaps
    always_ff @(posedge clk) begin
        if (rst || clear || load) begin
            bitIndex <= '0;
        end else if (count && bitIndex != INDEX_DONE) begin
            bitIndex <= bitIndex + 5'h01;
        end
    end

    // ****************************************************
    // bit presented after a falling edge
    // ****************************************************
    // most significant bit first
    always_ff @(posedge clk) begin
        if (rst || clear || load) begin
            serialBit <= 1'b1;
        end else if (advance && bitIndex < INDEX_DONE) begin
            serialBit <= word[INDEX_LAST - bitIndex];
        end
    end

endmodule

// [tb_top.sv]
/*
 * bench for the serial result port: slave, unread, master, deselect
 * assumes aro_port and aro_host_model are compiled before it
 */
`timescale 1ns/1ns
module tb_top
    import aro_pkg::*;
;
    // ****************************************************
    // signals
    // ****************************************************
    logic                 clk;
    logic                 rst;
    logic                 csN;
    logic                 modeSel;
    logic                 crystalClock;
    logic [WORD_BITS-1:0] resultData;
    logic                 sclkOut;
    logic                 sclkOe;
    logic                 doutRdy;
    logic                 doutOe;
    logic                 standby;
    logic                 sclkDrv;
    logic                 sclkDrvOe;
    logic                 sclkLine;
    logic                 dataLine;
    logic [23:0]          word;
    int                   bitCount;
    int                   failures  = 0;
    int                   numChecks = 0;
    int                   cycles    = 0;
    int                   xtalCount = 0;
    int                   mark;
    time                  lastRise  = 0;
    time                  riseGap   = 0;
    assign sclkLine = sclkOe ? sclkOut : (sclkDrvOe ? sclkDrv : 1'b1);
    assign dataLine = doutOe ? doutRdy : ~doutRdy;
    aro_port i_dut (
        .clk          (clk),
        .rst          (rst),
        .csN          (csN),
        .modeSel      (modeSel),
        .crystalClock (crystalClock),
        .sclkIn       (sclkLine),
        .resultData   (resultData),
        .sclkOut      (sclkOut),
        .sclkOe       (sclkOe),
        .doutRdy      (doutRdy),
        .doutOe       (doutOe),
        .standby      (standby)
    );
    aro_host_model i_host (
        .sclkLine  (sclkLine),
        .dataLine  (dataLine),
        .sclkDrv   (sclkDrv),
        .sclkDrvOe (sclkDrvOe),
        .word      (word),
        .bitCount  (bitCount)
    );
    // ****************************************************
    // clocks, timeout and shared tasks
    // ****************************************************
    always #5 clk = ~clk;
    always #30 crystalClock = ~crystalClock;
    always @(posedge crystalClock) xtalCount++;
    always @(posedge sclkLine) begin
        riseGap  = $time - lastRise;
        lastRise = $time;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wait_level(input logic lvl, input int lim);
        for (int n = 0; n < lim && doutRdy !== lvl; n++) @(negedge clk);
    endtask
    task automatic in_range(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic sel(input logic mode, input logic [23:0] data);
        @(posedge clk);
        modeSel    <= mode;
        csN        <= 1'b0;
        resultData <= data;
        mark       = xtalCount;
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset();
        @(negedge clk);
        check(sclkOe, 1'b0);
        check(doutOe, 1'b0);
        check(standby, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_slave();
        sel(1'b1, 24'hA5C3E1);
        repeat (8) @(negedge clk);
        check(standby, 1'b0);
        check(doutOe, 1'b1);
        check(doutRdy, 1'b1);
        check(sclkOe, 1'b0);
        wait_level(1'b0, 20400);
        in_range(xtalCount - mark, 3310, 3314);
        mark = xtalCount;
        i_host.clear_word();
        i_host.read_word(1'b1);
        repeat (8) @(negedge clk);
        check(word, 24'hA5C3E1);
        check(bitCount, 24);
        check(doutRdy, 1'b1);
        $display("test slave done");
    endtask
    task automatic t_unread();
        @(posedge clk);
        resultData <= 24'h3C5A96;
        wait_level(1'b0, 10200);
        in_range(xtalCount - mark, 1655, 1657);
        mark = xtalCount;
        @(posedge clk);
        resultData <= 24'h0F1E2D;
        wait_level(1'b1, 10200);
        in_range(xtalCount - mark, 1650, 1656);
        wait_level(1'b0, 60);
        check(doutRdy, 1'b0);
        i_host.clear_word();
        i_host.read_word(1'b0);
        repeat (8) @(negedge clk);
        check(word, 24'h0F1E2D);
        $display("test unread done");
    endtask
    task automatic t_master();
        int hi;
        @(posedge clk);
        csN <= 1'b1;
        repeat (6) @(negedge clk);
        check(doutOe, 1'b0);
        check(sclkOe, 1'b0);
        check(standby, 1'b1);
        i_host.clear_word();
        sel(1'b0, 24'h96C31B);
        wait_level(1'b0, 20400);
        in_range(xtalCount - mark, 3310, 3314);
        check(sclkOe, 1'b1);
        hi = 0;
        repeat (2) begin
            @(negedge clk);
            hi += int'(sclkOut) + int'(!doutRdy);
        end
        check(hi, 4);
        for (int k = 0; k < 600 && bitCount < 24; k++) @(negedge clk);
        repeat (4) @(posedge crystalClock);
        @(negedge clk);
        check(bitCount, 24);
        check(word, 24'h96C31B);
        check(riseGap, 60);
        check(sclkOut, 1'b1);
        check(doutRdy, 1'b1);
        $display("test master done");
    endtask
    initial begin
        clk          = 1'b0;
        crystalClock = 1'b0;
        rst          = 1'b1;
        csN          = 1'b1;
        modeSel      = 1'b1;
        resultData   = 24'h000000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_slave();
        t_unread();
        t_master();
        give_verdict();
    end
endmodule
